// ---- src/ddsc_top.sv ----
// Functional notes
// RULE_01: Serial bits enter the shift register only while select is low.
// RULE_02: Data is sampled and shifted on each rising serial clock edge.
// RULE_03: Word goes most significant bit first; spare one first, data lsb last.
// RULE_04: One command may span several transfers while select stays low.
// RULE_05: After sixteen bits, select rising executes loads and shutdown together.
// RULE_06: Control byte then data byte; each control bit acts on its own.
// RULE_07: Order: spares one-three, shutdown B, shutdown A, spare four, load B, A.
// RULE_08: Load bits copy the data byte into their channel; both get same byte.
// RULE_09: One command never gives the two channels different new codes.
// RULE_10: With both load bits low the codes stay and data is ignored.
// RULE_11: Shutdown bits set each channel off when high, active when low.
// RULE_12: Loads and shutdown settings of one command act at one edge.
// RULE_13: A channel in shutdown has its output off and keeps its code.
// RULE_14: Leaving shutdown the output shows the kept code again.
// RULE_15: Output equals reference times code over 256.
// RULE_16: The host writes once after power-up; contents start undefined; here reset loads both codes with 00 and both channels active.
// RULE_17: A host port uses clock polarity zero and phase zero.
// RULE_18: The host toggles the serial clock only when it transfers; the bench host model also toggles it with select high in idle_clocks.
// RULE_19: Host drives spare three high, spare four low; spares ignored here.
// RULE_20: While select is high nothing changes on serial clock edges.
// RULE_21: Commands act only on select rising, never on clock edges alone.
`timescale 1ns/1ps
module ddsc_top
  import ddsc_pkg::*;
(
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_SELECT_N,
  input  wire logic        I_SCLK,
  input  wire logic        I_DIN,
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [7:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic      [31:0] O_WB_DAT,
  output logic             O_WB_ACK,
  output logic      [7:0]  O_FIRST_CHANNEL_OUTPUT,
  output logic      [7:0]  O_SECOND_CHANNEL_OUTPUT,
  output logic             O_FIRST_CHANNEL_ENABLE,
  output logic             O_SECOND_CHANNEL_ENABLE
);

  // ----------------------------------------------------------------
  // Serial intake
  // ----------------------------------------------------------------
  logic [WORD_BITS-1:0] ser_word;
  logic [COUNT_W-1:0]   ser_count;
  logic                 ser_frame;
  logic                 ser_exec;

  ddsc_serial_in u_serial (
    .i_clk      (I_CLK),
    .i_rst_n    (I_RST_N),
    .i_select_n (I_SELECT_N),
    .i_sclk     (I_SCLK),
    .i_din      (I_DIN),
    .o_word     (ser_word),
    .o_count    (ser_count),
    .o_frame    (ser_frame),
    .o_exec     (ser_exec)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  code_a;
    logic [7:0]  code_b;
    logic        shdn_a;
    logic        shdn_b;
    logic        exec_en;
    logic [15:0] cmd_count;
    logic [15:0] last_word;
    logic        ack;
    logic [31:0] rdat;
    logic [7:0]  out_a;
    logic [7:0]  out_b;
    logic        en_a;
    logic        en_b;
  } ddsc_top_s;

  ddsc_top_s q;
  ddsc_top_s d;

  // Command fields, named once so the assertions below can use them.
  logic [7:0] cmd_data;
  logic       cmd_load_a;
  logic       cmd_load_b;
  logic       cmd_shdn_a;
  logic       cmd_shdn_b;
  logic       cmd_go;

  assign cmd_data = ser_word[DATA_MSB:DATA_LSB];
  assign cmd_load_a = ser_word[LOAD_FIRST_POS];
  assign cmd_load_b = ser_word[LOAD_SECOND_POS];
  assign cmd_shdn_a = ser_word[SHUTDOWN_FIRST_POS];
  assign cmd_shdn_b = ser_word[SHUTDOWN_SECOND_POS];
  assign cmd_go = ser_exec && q.exec_en;

  // ----------------------------------------------------------------
  // Execution, register bus and outputs
  // ----------------------------------------------------------------
  // The spare bits only reach last_word and never act; the host still sends spare three high
  // and spare four low so that the word stays compatible with wider parts.
  // Software can hold off execution through the control register, which is
  // useful while the board sequences its reference supply.
  always_comb
  begin
    d = q;
    d.ack = 1'b0;
    d.rdat = '0;
    if (cmd_go)
    begin
      if (cmd_load_a)
      begin
        d.code_a = cmd_data;  // [RULE_06] [RULE_07] [RULE_08] [RULE_09]
      end
      if (cmd_load_b)
      begin
        d.code_b = cmd_data;  // [RULE_06] [RULE_07] [RULE_08] [RULE_10]
      end
      d.shdn_a = cmd_shdn_a;  // [RULE_11] [RULE_12]
      d.shdn_b = cmd_shdn_b;  // [RULE_11] [RULE_12]
      d.cmd_count = q.cmd_count + 16'h0001;
      d.last_word = ser_word;
    end
    if (I_WB_CYC && I_WB_STB && !q.ack)
    begin
      d.ack = 1'b1;
      unique case (I_WB_ADR)
        ADDR_CTRL:
        begin
          d.rdat[CTRL_EXEC_EN_POS] = q.exec_en;
          if (I_WB_WE && I_WB_SEL[0])
          begin
            d.exec_en = I_WB_DAT[CTRL_EXEC_EN_POS];
          end
        end
        ADDR_STATUS:
        begin
          d.rdat[ST_CODE_A_LSB +: 8] = q.code_a;
          d.rdat[ST_CODE_B_LSB +: 8] = q.code_b;
          d.rdat[ST_SHDN_A_POS] = q.shdn_a;
          d.rdat[ST_SHDN_B_POS] = q.shdn_b;
          d.rdat[ST_FRAME_POS] = ser_frame;
          d.rdat[ST_COUNT_LSB +: COUNT_W] = ser_count;
        end
        ADDR_COUNT:
        begin
          d.rdat[15:0] = q.cmd_count;
        end
        ADDR_LAST:
        begin
          d.rdat[15:0] = q.last_word;
        end
        default:
        begin
          d.rdat = '0;
        end
      endcase
    end
    // Output level is reference times value over 256; zero while shut down.
    d.out_a = d.shdn_a ? 8'h00 : d.code_a;  // [RULE_13] [RULE_14] [RULE_15]
    d.out_b = d.shdn_b ? 8'h00 : d.code_b;  // [RULE_13] [RULE_14] [RULE_15]
    d.en_a = !d.shdn_a;
    d.en_b = !d.shdn_b;
  end

  // Reset gives defined values even though the real part has none.
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      q <= '{code_a: CODE_RESET, code_b: CODE_RESET, shdn_a: SHUTDOWN_RESET,
             shdn_b: SHUTDOWN_RESET, exec_en: CTRL_EXEC_EN_RESET,
             en_a: !SHUTDOWN_RESET, en_b: !SHUTDOWN_RESET, default: '0};
    end
    else
    begin
      q <= d;
    end
  end

  assign O_WB_DAT = q.rdat;
  assign O_WB_ACK = q.ack;
  assign O_FIRST_CHANNEL_OUTPUT = q.out_a;
  assign O_SECOND_CHANNEL_OUTPUT = q.out_b;
  assign O_FIRST_CHANNEL_ENABLE = q.en_a;
  assign O_SECOND_CHANNEL_ENABLE = q.en_b;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);

  sequence s_load_a;
    cmd_go && cmd_load_a;
  endsequence

  sequence s_load_both;
    cmd_go && cmd_load_a && cmd_load_b;
  endsequence

  sequence s_no_load;
    cmd_go && !cmd_load_a && !cmd_load_b;
  endsequence

  sequence s_shut_a;
    cmd_go && cmd_shdn_a;
  endsequence

  a_load_first_code: assert property (  // [RULE_08]
    s_load_a |=> q.code_a == $past(cmd_data))
    else $error("First channel code not loaded from data byte.");

  a_both_same_code: assert property (  // [RULE_09]
    s_load_both |=> q.code_a == q.code_b)
    else $error("Both loads gave different codes.");

  a_no_load_holds: assert property (  // [RULE_10]
    s_no_load |=> $stable(q.code_a) && $stable(q.code_b))
    else $error("Code changed without a load bit.");

  a_shutdown_follows: assert property (  // [RULE_11]
    cmd_go |=> q.shdn_a == $past(cmd_shdn_a) && q.shdn_b == $past(cmd_shdn_b))
    else $error("Shutdown state does not follow the command.");

  a_shut_output_off: assert property (  // [RULE_13]
    s_shut_a |=> O_FIRST_CHANNEL_OUTPUT == 8'h00 && !O_FIRST_CHANNEL_ENABLE
      && ($stable(q.code_a) || $past(cmd_load_a)))
    else $error("Shut down channel still drives its output.");

  a_wake_restores: assert property (  // [RULE_14]
    $fell(q.shdn_b) |-> O_SECOND_CHANNEL_OUTPUT == q.code_b && O_SECOND_CHANNEL_ENABLE)
    else $error("Second channel did not restore its kept code.");

  a_level_matches: assert property (  // [RULE_15]
    !q.shdn_a |-> O_FIRST_CHANNEL_OUTPUT == q.code_a)
    else $error("Active output differs from stored code.");

  a_only_on_select: assert property (  // [RULE_21]
    !ser_exec |=> $stable(q.code_a) && $stable(q.code_b) && $stable(q.shdn_a)
      && $stable(q.shdn_b))
    else $error("State changed without an execute edge.");

  a_idle_no_count: assert property (  // [RULE_20]
    !ser_frame |=> ser_count == '0)
    else $error("Bit count kept while select is high.");

  a_count_bounded: assert property (  // [RULE_04]
    ser_frame && ser_count != FULL_COUNT ##1 ser_frame |-> ser_count <= FULL_COUNT)
    else $error("Bit count ran past a full word.");

  a_ack_single: assert property (
    O_WB_ACK |=> !O_WB_ACK)
    else $error("Bus acknowledge held longer than one cycle.");

endmodule

// ---- src/ddsc_pkg.sv ----
package ddsc_pkg;

  // ----------------------------------------------------------------
  // Command word layout
  // ----------------------------------------------------------------
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned COUNT_W = 5;
  localparam logic [4:0] FULL_COUNT = 5'h10;
  localparam int unsigned SPARE_BIT_ONE_POS = 15;
  localparam int unsigned SPARE_BIT_TWO_POS = 14;
  localparam int unsigned SPARE_BIT_THREE_POS = 13;
  localparam int unsigned SHUTDOWN_SECOND_POS = 12;
  localparam int unsigned SHUTDOWN_FIRST_POS = 11;
  localparam int unsigned SPARE_BIT_FOUR_POS = 10;
  localparam int unsigned LOAD_SECOND_POS = 9;
  localparam int unsigned LOAD_FIRST_POS = 8;
  localparam int unsigned DATA_MSB = 7;
  localparam int unsigned DATA_LSB = 0;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic [7:0] ADDR_LAST = 8'h0C;
  localparam int unsigned CTRL_EXEC_EN_POS = 0;
  localparam logic CTRL_EXEC_EN_RESET = 1'b1;
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam logic SHUTDOWN_RESET = 1'b0;

  // Status word field positions.
  localparam int unsigned ST_CODE_A_LSB = 0;
  localparam int unsigned ST_CODE_B_LSB = 8;
  localparam int unsigned ST_SHDN_A_POS = 16;
  localparam int unsigned ST_SHDN_B_POS = 17;
  localparam int unsigned ST_FRAME_POS = 18;
  localparam int unsigned ST_COUNT_LSB = 24;

endpackage

// ---- src/ddsc_serial_in.sv ----
`timescale 1ns/1ps
module ddsc_serial_in
  import ddsc_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_select_n,
  input  wire logic                 i_sclk,
  input  wire logic                 i_din,
  output logic      [WORD_BITS-1:0] o_word,
  output logic      [COUNT_W-1:0]   o_count,
  output logic                      o_frame,
  output logic                      o_exec
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                 sel_m;
    logic                 sel_s;
    logic                 sel_p;
    logic                 clk_m;
    logic                 clk_s;
    logic                 clk_p;
    logic                 din_m;
    logic                 din_s;
    logic [WORD_BITS-1:0] word;
    logic [COUNT_W-1:0]   count;
    logic                 exec;
  } ddsc_ser_s;

  ddsc_ser_s q;
  ddsc_ser_s d;

  // ----------------------------------------------------------------
  // Shift and execute
  // ----------------------------------------------------------------
  // Data and clock share the same synchroniser depth, so the data bit seen
  // with a clock edge is the one the host set up before that edge.
  always_comb
  begin
    d = q;
    d.sel_m = i_select_n;
    d.sel_s = q.sel_m;
    d.sel_p = q.sel_s;
    d.clk_m = i_sclk;
    d.clk_s = q.clk_m;
    d.clk_p = q.clk_s;
    d.din_m = i_din;
    d.din_s = q.din_m;
    d.exec = 1'b0;
    if (!q.sel_s)
    begin
      if (q.clk_s && !q.clk_p)
      begin
        d.word = {q.word[WORD_BITS-2:0], q.din_s};  // [RULE_01] [RULE_02] [RULE_03]
        if (q.count != FULL_COUNT)
        begin
          d.count = q.count + 5'h01;  // [RULE_04]
        end
      end
    end
    else
    begin
      d.count = '0;  // [RULE_20]
      if (!q.sel_p && q.count == FULL_COUNT)
      begin
        d.exec = 1'b1;  // [RULE_05] [RULE_21]
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      q <= '{sel_m: 1'b1, sel_s: 1'b1, sel_p: 1'b1, default: '0};
    end
    else
    begin
      q <= d;
    end
  end

  assign o_word = q.word;
  assign o_count = q.count;
  assign o_frame = !q.sel_s;
  assign o_exec = q.exec;

endmodule

// ---- bench/ddsc_host_model.sv ----
`timescale 1ns/1ps
module ddsc_host_model
(
  input  wire logic i_clk,
  output logic      o_select_n,
  output logic      o_sclk,
  output logic      o_din
);
  logic busy = 1'b0;
  initial
  begin
    o_select_n = 1'b1;
    o_sclk = 1'b0;
    o_din = 1'b0;
  end
  // An idle data line keeps moving, so a stale bit never looks valid.
  always @(posedge i_clk)
  begin
    if (!busy)
    begin
      o_din <= ~o_din;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // Clock idles low; data changes on the falling edge.
  task automatic send(input logic [31:0] w, input int nb, input bit split);
    busy = 1'b1;
    @(posedge i_clk);
    o_select_n <= 1'b0;
    tick(4);
    for (int i = nb - 1; i >= 0; i--)
    begin
      o_din <= w[i];
      tick(4);
      o_sclk <= 1'b1;
      tick(4);
      o_sclk <= 1'b0;
      if (split && i == 8) tick(12);
    end
    tick(4);
    o_select_n <= 1'b1;
    busy = 1'b0;
  endtask
  task automatic idle_clocks(input int n);
    repeat (n)
    begin
      o_sclk <= 1'b1;
      tick(4);
      o_sclk <= 1'b0;
      tick(4);
    end
  endtask
endmodule

// ---- bench/ddsc_top_bench.sv ----
`timescale 1ns/1ps
module ddsc_top_bench;
  import ddsc_pkg::*;
  logic        clk, rst_n, cyc, stb, we, sn, sck, din;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dwr, dr;
  logic [7:0]  oa, ob;
  logic        ea, eb, ack;
  logic [7:0]  ca, cb;
  logic        sa, sb, xen;
  logic [15:0] nx, lw;
  logic [17:0] pv, exp_o[$];
  logic [63:0] exp_r[$];
  int          num_errors, comparisons, cycles;
  integer      seed = 32'hCF8FE79F;
  ddsc_top u_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_SELECT_N(sn), .I_SCLK(sck),
    .I_DIN(din), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
    .I_WB_SEL(sel), .I_WB_DAT(dwr), .O_WB_DAT(dr), .O_WB_ACK(ack),
    .O_FIRST_CHANNEL_OUTPUT(oa), .O_SECOND_CHANNEL_OUTPUT(ob),
    .O_FIRST_CHANNEL_ENABLE(ea), .O_SECOND_CHANNEL_ENABLE(eb));
  ddsc_host_model u_host (.i_clk(clk), .o_select_n(sn), .o_sclk(sck), .o_din(din));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [17:0] outs();
    return {sa ? 8'h00 : ca, sb ? 8'h00 : cb, !sa, !sb};
  endfunction
  task automatic cmp(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
    comparisons++;
    if ((g & m) !== (e & m))
    begin
      num_errors++;
      $display("ERROR t=%0t got %h expected %h", $time, g & m, e & m);
    end
  endtask
  // ----------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------
  // A change nobody announced finds the queue empty, is compared against its own inverse and is reported.
  always @(posedge clk)
  begin
    if (rst_n && {oa, ob, ea, eb} !== pv)
    begin
      pv = {oa, ob, ea, eb};
      cmp({14'h0, pv}, {14'h0, exp_o.size() ? exp_o.pop_front() : ~pv}, 32'h3FFFF);
    end
    if (rst_n && ack === 1'b1)
    begin
      cmp(dr, exp_r[0][63:32], exp_r.size() ? exp_r[0][31:0] : 32'hFFFFFFFF);
      if (exp_r.size()) void'(exp_r.pop_front());
    end
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      $display("ERROR t=%0t run timed out", $time);
      summarize();
    end
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] e, input logic [31:0] m);
    exp_r.push_back({e, m});
    @(posedge clk);
    {cyc, stb, we, adr, dwr, sel} <= {2'b11, w, a, d, 4'hF};
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    {cyc, stb, we} <= 3'b000;
  endtask
  task automatic status();
    wb(0, ADDR_STATUS, 0, {13'h0, 1'b0, sb, sa, cb, ca}, 32'h1F07FFFF);
    wb(0, ADDR_COUNT, 0, {16'h0, nx}, 32'hFFFF);
    wb(0, ADDR_LAST, 0, {16'h0, lw}, 32'hFFFF);
  endtask
  task automatic cmd(input logic s_a, s_b, l_a, l_b, input logic [7:0] d,
                     input int nb, input bit split);
    logic [31:0] r = $random(seed);
    logic [15:0] w = {r[1:0], 1'b1, s_b, s_a, 1'b0, l_b, l_a, d};
    logic [17:0] b = outs();
    if (nb >= 16 && xen)
    begin
      if (l_a) ca = d;
      if (l_b) cb = d;
      {sa, sb, nx, lw} = {s_a, s_b, nx + 16'h1, w};
    end
    if (outs() !== b) exp_o.push_back(outs());
    u_host.send({r[31:16], w}, nb, split);
    repeat (12) @(posedge clk);
    status();
  endtask
  task automatic summarize();
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rst_n, cyc, stb, we, adr, sel, dwr} = '0;
    {ca, cb, sa, sb, xen, nx, lw} = {16'h0, 2'b00, 1'b1, 32'h0};
    {num_errors, comparisons, cycles} = '0;
    pv = outs();
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    cmp({14'h0, oa, ob, ea, eb}, {14'h0, outs()}, 32'h3FFFF);
    wb(0, ADDR_CTRL, 0, 32'h1, 32'h1);
    wb(1, 8'h10, 32'h5A, 0, 0);
    wb(0, 8'h10, 0, 0, 32'hFFFFFFFF);
    status();
    $display("reset and map test done");
    for (int k = 0; k < 16; k++) cmd(k[0], k[1], k[2], k[3], 8'h11 * k[7:0], 16, 0);
    repeat (8) cmd($random(seed), $random(seed), $random(seed), $random(seed),
                   $random(seed), 16, 0);
    cmd(1, 1, 0, 0, 8'hFF, 16, 0);
    cmd(0, 0, 0, 0, 8'h00, 16, 0);
    $display("command table test done");
    cmd(0, 0, 1, 1, 8'h80, 16, 1);
    cmd(1, 0, 1, 0, 8'h3C, 15, 0);
    cmd(0, 1, 0, 1, 8'hC3, 17, 0);
    u_host.idle_clocks(6);
    status();
    $display("framing test done");
    wb(1, ADDR_CTRL, 0, 0, 0);
    xen = 1'b0;
    cmd(1, 1, 1, 1, 8'h7E, 16, 0);
    wb(1, ADDR_CTRL, 1, 0, 0);
    xen = 1'b1;
    wb(0, ADDR_CTRL, 0, 1, 1);
    cmd(0, 1, 1, 0, 8'h01, 16, 0);
    $display("exec enable test done");
    if (exp_o.size() != 0) cmp(0, 1, 1);
    summarize();
  end
endmodule
